// >>> verilog/csc_capture.sv
// Camera sensor pixel capture front end, oversampling the sensor pins on the system clock
`include "csc_defines.svh"
// Every sensor pin is oversampled on ref_clk through two flops, so the pixel clock must stay well below
// ref_clk; each pixel clock phase needs at least two system clocks to be seen reliably.
// Pixel data passes the same two flops as the pixel clock, so the word that stands at a detected
// sampling edge is the word the sensor held around that edge.
// After a frame edge the port ignores pixels for a fixed guard wait and flags a line start in gated mode,
// or a pixel in non-gated mode, that arrives inside it; a frame edge inside the wait starts the wait again.
// The sensor cannot be stalled, so a full buffer drops pixels and raises a sticky overflow flag
// that clears at the next frame edge; a set in the same cycle wins over the clear.
// Mode selects are plain level inputs; change them only between frames, as a change mid-line
// may move the sampling edge and take one pixel twice or miss one.

// How it works
// - Gated mode uses frame sync, line strobe and pixel clock together to frame and sample pixels.
// - A frame starts on the selected edge of frame sync, rising or falling.
// - In gated mode only pixel clock edges seen while the line strobe is high carry pixels.
// - With data launched on the falling edge, the bus is sampled on the rising pixel clock edge.
// - With data launched on the rising edge, the bus is sampled on the falling pixel clock edge.
// - Non-gated mode ignores the line strobe and uses only frame sync and pixel clock.
module csc_capture
	import csc_pkg::*;
(
	input  wire logic                   ref_clk,       // System clock, 10 MHz
	input  wire logic                   reset,         // Synchronous reset, active high
	input  wire logic                   gated_mode,    // 1 gated, 0 non-gated
	input  wire logic                   vsync_fall,    // 1 frame starts on falling frame sync edge
	input  wire logic                   sample_fall,   // 1 sample on falling pixel clock edge
	input  wire logic                   frame_sync,    // Sensor frame sync pin
	input  wire logic                   line_valid,    // Sensor line strobe pin
	input  wire logic                   pixel_clk,     // Sensor pixel clock pin
	input  wire logic [`CSC_DATA_W-1:0] pixel_data,    // Sensor data bus
	output logic [`CSC_DATA_W-1:0]      px_data,       // Pixel word out
	output logic                        px_frame_start,// First pixel of frame
	output logic                        px_line_start, // First pixel of line
	output logic                        px_valid,      // Pixel word valid
	input  wire logic                   px_ready,      // Consumer accepts word
	output logic                        overflow,      // Pixel dropped, FIFO full (sticky per frame)
	output logic                        gap_error      // Line (gated) or pixel clock (non-gated) came inside the guard gap
);
	// Two-flop synchronisers on every sensor pin
	logic [2:0]             meta_ctl;
	logic [2:0]             sync_ctl;
	logic [`CSC_DATA_W-1:0] meta_data;
	logic [`CSC_DATA_W-1:0] sync_data;
	logic [2:0]             prev_ctl;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			meta_ctl  <= 3'h0;
			sync_ctl  <= 3'h0;
			meta_data <= 8'h00;
			sync_data <= 8'h00;
			prev_ctl  <= 3'h0;
		end else begin
			meta_ctl  <= {frame_sync, line_valid, pixel_clk};
			sync_ctl  <= meta_ctl;
			meta_data <= pixel_data;
			sync_data <= meta_data;
			prev_ctl  <= sync_ctl;
		end
	end

	// Edge detection on synchronised pins; data lags pins equally so it is stable at the edge
	wire vs_s    = sync_ctl[2];
	wire lv_s    = sync_ctl[1];
	wire pc_s    = sync_ctl[0];
	wire vs_rise = vs_s & ~prev_ctl[2];
	wire vs_fall = ~vs_s & prev_ctl[2];
	wire pc_rise = pc_s & ~prev_ctl[0];
	wire pc_fall = ~pc_s & prev_ctl[0];
	wire lv_rise = lv_s & ~prev_ctl[1];
	wire frame_edge  = vsync_fall ? vs_fall : vs_rise;
	wire sample_edge = sample_fall ? pc_fall : pc_rise;
	wire line_open   = gated_mode ? lv_s : 1'b1;
	wire line_begin  = gated_mode & lv_rise;

	// Frame state: wait out the guard gap after frame start before accepting pixels
	csc_state_t                state;
	csc_state_t                next_state;
	logic [`CSC_GAP_CNT_W-1:0] gap_cnt;
	logic                      first_frame;
	logic                      first_line;
	wire gap_done = (gap_cnt == `CSC_GAP_CNT_W'(`CSC_VS_GAP_CYC - 1));
	wire early    = (state == CSC_WAIT) & (gated_mode ? lv_rise : sample_edge);
	always_comb begin
		next_state = state;
		case (state)
			CSC_IDLE:  if (frame_edge) next_state = CSC_WAIT;
			CSC_WAIT:  if (gap_done && !frame_edge) next_state = CSC_FRAME;
			CSC_FRAME: if (frame_edge) next_state = CSC_WAIT;
			default:   next_state = CSC_IDLE;
		endcase
	end

	// Pixel take, with tags for first pixel of frame and of line
	wire take = (state == CSC_FRAME) & sample_edge & line_open;
	csc_pixel_t in_word;
	// A line rise in the same cycle as a take still tags that word as the line's first
	wire        line_tag = first_line | (line_begin & (state == CSC_FRAME));
	assign in_word = '{frame_start: first_frame, line_start: line_tag, data: sync_data};
	wire fifo_in_ready;

	// State, gap counter and tag flags
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state       <= CSC_IDLE;
			gap_cnt     <= '0;
			first_frame <= 1'b0;
			first_line  <= 1'b0;
		end else begin
			state   <= next_state;
			gap_cnt <= (state == CSC_WAIT && !gap_done && !frame_edge) ? gap_cnt + 1'b1 : '0;
			if (frame_edge) begin
				first_frame <= 1'b1;
				first_line  <= 1'b1;
			end else if (take) begin
				first_frame <= 1'b0;
				first_line  <= 1'b0;
			end else if (line_begin && state == CSC_FRAME)
				first_line <= 1'b1;
		end
	end

	// Error flags: overflow sticks until the next frame starts, gap error likewise
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			overflow  <= 1'b0;
			gap_error <= 1'b0;
		end else begin
			if (take && !fifo_in_ready)
				overflow <= 1'b1; // Set wins over the frame clear
			else if (frame_edge)
				overflow <= 1'b0;
			if (early)
				gap_error <= 1'b1;
			else if (frame_edge)
				gap_error <= 1'b0;
		end
	end

	// FIFO buffers pixels against consumer stalls; a full FIFO drops and flags since the sensor cannot wait
	csc_pixel_t fifo_out;
	logic       fifo_valid;
	wire        out_take = ~px_valid | px_ready;
	csc_fifo #(
		.WIDTH($bits(csc_pixel_t)),
		.DEPTH(`CSC_FIFO_DEPTH)
	) u_fifo (
		.ref_clk  (ref_clk),
		.reset    (reset),
		.in_data  (in_word),
		.in_valid (take),
		.in_ready (fifo_in_ready),
		.out_data (fifo_out),
		.out_valid(fifo_valid),
		.out_ready(out_take)
	);

	// Output register stage so every output comes from a flop
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			px_valid       <= 1'b0;
			px_data        <= 8'h00;
			px_frame_start <= 1'b0;
			px_line_start  <= 1'b0;
		end else if (out_take) begin
			px_valid       <= fifo_valid;
			px_data        <= fifo_out.data;
			px_frame_start <= fifo_out.frame_start;
			px_line_start  <= fifo_out.line_start;
		end
	end

	// Checks on the capture behaviour
	// Any frame edge lands in the guard wait, also one that arrives during the wait
	frame_edge_wait_a: assert property (@(posedge ref_clk) disable iff (reset)
		frame_edge |=> state == CSC_WAIT)
		else $error("Frame edge did not start guard wait");
	// An undisturbed wait lasts exactly nine cycles before pixels are accepted
	gap_length_a: assert property (@(posedge ref_clk) disable iff (reset)
		(state != CSC_WAIT) ##1 (state == CSC_WAIT && !frame_edge) ##1 (!frame_edge) [*8] |=> state == CSC_FRAME)
		else $error("Guard wait length wrong");
	// Gated mode takes nothing while the line strobe is low
	gated_no_line_a: assert property (@(posedge ref_clk) disable iff (reset)
		gated_mode && !lv_s |-> !take)
		else $error("Pixel taken outside line strobe");
	// Non-gated mode takes every selected edge inside a frame
	nongated_take_a: assert property (@(posedge ref_clk) disable iff (reset)
		!gated_mode && state == CSC_FRAME && sample_edge |-> take)
		else $error("Non-gated pixel edge missed");
	// Rising sampling takes only on a low to high pixel clock change
	rise_sample_a: assert property (@(posedge ref_clk) disable iff (reset)
		take && !sample_fall |-> pc_s && !$past(pc_s))
		else $error("Rising sample on wrong edge");
	// Falling sampling takes only on a high to low pixel clock change
	fall_sample_a: assert property (@(posedge ref_clk) disable iff (reset)
		take && sample_fall |-> !pc_s && $past(pc_s))
		else $error("Falling sample on wrong edge");
	// The word after a frame edge carries both tags
	frame_tag_a: assert property (@(posedge ref_clk) disable iff (reset)
		frame_edge |=> in_word.frame_start && in_word.line_start)
		else $error("Frame start tag missing");
	// No pixel is taken before the frame opens
	take_no_idle_a: assert property (@(posedge ref_clk) disable iff (reset)
		state != CSC_FRAME |-> !take)
		else $error("Pixel taken outside frame");

	// Rising frame sync selected: the edge is a low to high change
	frame_rise_a: assert property (@(posedge ref_clk) disable iff (reset)
		frame_edge && !vsync_fall |-> vs_s && !$past(vs_s))
		else $error("Frame start on wrong sync edge");
	// Falling frame sync selected: the edge is a high to low change
	frame_fall_a: assert property (@(posedge ref_clk) disable iff (reset)
		frame_edge && vsync_fall |-> !vs_s && $past(vs_s))
		else $error("Frame start on wrong sync edge");
	// Idle holds until a frame edge
	idle_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
		state == CSC_IDLE && !frame_edge |=> state == CSC_IDLE)
		else $error("Idle left without frame edge");
	// An open frame stays open until the next frame edge
	frame_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
		state == CSC_FRAME && !frame_edge |=> state == CSC_FRAME)
		else $error("Frame closed without frame edge");
	// The wait never ends early, whatever the pins do
	gap_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
		$rose(state == CSC_WAIT) |-> (state == CSC_WAIT) [*8] ##1 (state == CSC_WAIT))
		else $error("Guard wait ended early");
	// Only the three coded states occur
	state_legal_a: assert property (@(posedge ref_clk) disable iff (reset)
		state == CSC_IDLE || state == CSC_WAIT || state == CSC_FRAME)
		else $error("Frame state illegal");

	// A line rise (gated) or sampling edge (non-gated) inside the wait raises the gap flag
	gap_set_a: assert property (@(posedge ref_clk) disable iff (reset)
		early |=> gap_error)
		else $error("Gap flag not set");
	// A frame edge without a new violation clears the gap flag
	gap_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
		frame_edge && !early |=> !gap_error)
		else $error("Gap flag not cleared");
	// The gap flag sticks between events
	gap_keep_a: assert property (@(posedge ref_clk) disable iff (reset)
		!early && !frame_edge |=> $stable(gap_error))
		else $error("Gap flag moved without cause");
	// A take into a full buffer raises the overflow flag
	ovf_set_a: assert property (@(posedge ref_clk) disable iff (reset)
		take && !fifo_in_ready |=> overflow)
		else $error("Overflow flag not set");
	// A frame edge without a new drop clears the overflow flag
	ovf_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
		frame_edge && !(take && !fifo_in_ready) |=> !overflow)
		else $error("Overflow flag not cleared");
	// The overflow flag sticks between events
	ovf_keep_a: assert property (@(posedge ref_clk) disable iff (reset)
		!(take && !fifo_in_ready) && !frame_edge |=> $stable(overflow))
		else $error("Overflow flag moved without cause");

	// Gated mode takes every selected edge while the strobe is high
	gated_take_a: assert property (@(posedge ref_clk) disable iff (reset)
		gated_mode && lv_s && state == CSC_FRAME && sample_edge |-> take)
		else $error("Gated pixel edge missed");
	// Non-gated mode takes pixels although the strobe is low
	line_ignored_a: assert property (@(posedge ref_clk) disable iff (reset)
		!gated_mode && !lv_s && state == CSC_FRAME && sample_edge |-> take)
		else $error("Line strobe not ignored");
	// Nothing is taken during the guard wait
	wait_no_take_a: assert property (@(posedge ref_clk) disable iff (reset)
		state == CSC_WAIT |-> !take)
		else $error("Pixel taken during guard wait");
	// One sampling edge gives one word, never two in a row
	take_spacing_a: assert property (@(posedge ref_clk) disable iff (reset)
		take |=> !take)
		else $error("Pixel taken twice");

	// A take clears the frame tag unless a new frame starts
	tag_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
		take && !frame_edge |=> !first_frame)
		else $error("Frame tag not cleared");
	// A line rise inside a frame arms the line tag
	line_tag_a: assert property (@(posedge ref_clk) disable iff (reset)
		line_begin && state == CSC_FRAME && !frame_edge && !take |=> first_line)
		else $error("Line tag not armed");
	// A take in the line rise cycle is tagged at once
	line_tag_now_a: assert property (@(posedge ref_clk) disable iff (reset)
		take && line_begin |-> in_word.line_start)
		else $error("Line tag missing");

	// Data passes both synchroniser flops in turn
	sync_data_a: assert property (@(posedge ref_clk) disable iff (reset)
		1'b1 |=> sync_data == $past(meta_data))
		else $error("Data synchroniser skipped a stage");
	// An accepted take is in the buffer the next cycle
	fifo_write_a: assert property (@(posedge ref_clk) disable iff (reset)
		take && fifo_in_ready |=> fifo_valid)
		else $error("Taken word not buffered");
	// A stalled output word stands unchanged
	px_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
		px_valid && !px_ready |=> px_valid && $stable(px_data) && $stable(px_frame_start) && $stable(px_line_start))
		else $error("Output word changed while stalled");
	// A free output stage loads the buffer head
	px_load_a: assert property (@(posedge ref_clk) disable iff (reset)
		fifo_valid && out_take |=> px_valid && px_data == $past(fifo_out.data))
		else $error("Output stage did not load head");
	// A free output stage with an empty buffer goes idle
	px_drain_a: assert property (@(posedge ref_clk) disable iff (reset)
		!fifo_valid && out_take |=> !px_valid)
		else $error("Output valid without data");
endmodule

// >>> verilog/csc_defines.svh
// Timing counts and field constants for the camera sensor pixel capture block
`ifndef CSC_DEFINES_SVH
`define CSC_DEFINES_SVH
`define CSC_DATA_W         8
`define CSC_FIFO_DEPTH     8
`define CSC_CLK_MHZ        10
`define CSC_SYS_PERIOD_NS  100
`define CSC_VS_GAP_PERIODS 9
`define CSC_VS_GAP_CYC     ((`CSC_VS_GAP_PERIODS * `CSC_SYS_PERIOD_NS + `CSC_SYS_PERIOD_NS - 1) / `CSC_SYS_PERIOD_NS)
`define CSC_GAP_CNT_W      4
`endif

// >>> verilog/csc_pkg.sv
// Types shared by the camera sensor pixel capture block
package csc_pkg;
	typedef struct packed {
		logic       frame_start;
		logic       line_start;
		logic [7:0] data;
	} csc_pixel_t;
	typedef enum logic [1:0] {
		CSC_IDLE  = 2'b00,
		CSC_WAIT  = 2'b01,
		CSC_FRAME = 2'b11
	} csc_state_t;
endpackage

// >>> verilog/csc_fifo.sv
// Small synchronous FIFO with valid and ready on both sides
module csc_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 8
) (
	input  wire logic             ref_clk,  // System clock
	input  wire logic             reset,    // Synchronous reset
	input  wire logic [WIDTH-1:0] in_data,  // Write word
	input  wire logic             in_valid, // Write request
	output logic                  in_ready, // Space available
	output logic [WIDTH-1:0]      out_data, // Head word
	output logic                  out_valid,// Head valid
	input  wire logic             out_ready // Consumer takes head
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	wire              do_wr = in_valid & in_ready;
	wire              do_rd = out_valid & out_ready;
	// Full and empty from pointer wrap bits
	assign in_ready  = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) | (wr_ptr[AW] == rd_ptr[AW]);
	assign out_valid = (wr_ptr != rd_ptr);
	assign out_data  = mem[rd_ptr[AW-1:0]];
	// Storage and pointers
	always_ff @(posedge ref_clk) begin
		if (do_wr)
			mem[wr_ptr[AW-1:0]] <= in_data;
		if (reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (do_wr)
				wr_ptr <= wr_ptr + 1'b1;
			if (do_rd)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule

// >>> dv/csc_sensor.sv
// Behavioural image sensor driving the parallel capture pins
`include "csc_defines.svh"
module csc_sensor (
	input  wire logic                   ref_clk,     // Bench system clock
	input  wire logic                   vsync_fall,  // Frame edge polarity in use
	input  wire logic                   sample_fall, // Capture edge in use
	output logic                        frame_sync,  // Frame sync pin
	output logic                        line_valid,  // Line strobe pin
	output logic                        pixel_clk,   // Pixel clock pin
	output logic [`CSC_DATA_W-1:0]      pixel_data   // Data bus
);
	timeunit 1ns;
	timeprecision 100ps;
	// Pins start idle; the pixel clock stands still outside frames
	initial begin
		frame_sync = 1'b0;
		line_valid = 1'b0;
		pixel_clk = 1'b1;
		pixel_data = 8'h00;
	end
	// Idle clock sits on the launch side so each toggle pair is one pixel
	task automatic rest();
		@(posedge ref_clk) pixel_clk <= ~sample_fall;
		@(posedge ref_clk) frame_sync <= vsync_fall;
	endtask
	// Frame edge, then a gap before any line or pixel clock
	task automatic frame(int n);
		@(posedge ref_clk) frame_sync <= ~vsync_fall;
		repeat (n) @(posedge ref_clk);
	endtask
	// Line strobe held across the whole line
	task automatic strobe(logic v);
		@(posedge ref_clk) line_valid <= v;
		repeat (4) @(posedge ref_clk);
	endtask
	// One pixel, 800 ns clock; bus garbled once hold time has run out
	task automatic pixel(logic [7:0] d);
		@(posedge ref_clk) pixel_clk <= sample_fall;
		pixel_data <= d;
		repeat (4) @(posedge ref_clk);
		pixel_clk <= ~sample_fall;
		repeat (2) @(posedge ref_clk);
		pixel_data <= ~d;
		repeat (1) @(posedge ref_clk);
	endtask
endmodule

// >>> dv/tb_top.sv
// Self-checking bench for the pixel capture front end
`include "csc_defines.svh"
module tb_top;
	import csc_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = 1'b0;
	logic reset, gated_mode, vsync_fall, sample_fall, px_ready;
	logic frame_sync, line_valid, pixel_clk, px_frame_start, px_line_start, px_valid, overflow, gap_error;
	logic [`CSC_DATA_W-1:0] pixel_data, px_data;
	logic [9:0] q[$];
	int fail_count = 0, checks_done = 0, cycles = 0;
	// System clock, 100 ns period
	always #50 ref_clk = ~ref_clk;
	csc_sensor u_sensor (.ref_clk, .vsync_fall, .sample_fall, .frame_sync, .line_valid, .pixel_clk, .pixel_data);
	csc_capture u_dut (.ref_clk, .reset, .gated_mode, .vsync_fall, .sample_fall, .frame_sync, .line_valid,
		.pixel_clk, .pixel_data, .px_data, .px_frame_start, .px_line_start, .px_valid, .px_ready, .overflow,
		.gap_error);
	// Consumer collects accepted words with tags; a hang is cut short
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (px_valid === 1'b1 && px_ready === 1'b1)
			q.push_back({px_frame_start, px_line_start, px_data});
		if (cycles == 20000) begin
			fail_count++;
			summarize();
		end
	end
	task automatic chk(string name, logic [9:0] seen, logic [9:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic summarize();
		if (fail_count == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Mode pins settle before the frame edge so stray words are discarded
	task automatic mode(logic g, logic vf, logic sf, int gap);
		@(posedge ref_clk);
		gated_mode <= g;
		vsync_fall <= vf;
		sample_fall <= sf;
		repeat (10) @(posedge ref_clk);
		u_sensor.rest();
		repeat (10) @(posedge ref_clk);
		u_sensor.frame(gap);
		q.delete();
	endtask
	task automatic t_gated();
		mode(1'b1, 1'b0, 1'b0, 20);
		u_sensor.pixel(8'h5a);
		u_sensor.strobe(1'b1);
		for (int i = 0; i < 3; i++) u_sensor.pixel(8'(8'ha0 + i));
		u_sensor.strobe(1'b0);
		u_sensor.strobe(1'b1);
		for (int i = 0; i < 2; i++) u_sensor.pixel(8'(8'hb0 + i));
		u_sensor.strobe(1'b0);
		repeat (12) @(posedge ref_clk);
		chk("g_count", 10'(q.size()), 10'h005);
		chk("g_word0", q[0], 10'h3a0);
		chk("g_word2", q[2], 10'h0a2);
		chk("g_word3", q[3], 10'h1b0);
		chk("g_word4", q[4], 10'h0b1);
	endtask
	task automatic t_nongated();
		mode(1'b0, 1'b1, 1'b1, 20);
		for (int i = 0; i < 3; i++) u_sensor.pixel(8'(8'hc0 + i));
		repeat (12) @(posedge ref_clk);
		chk("n_count", 10'(q.size()), 10'h003);
		chk("n_word0", q[0], 10'h3c0);
		chk("n_word2", q[2], 10'h0c2);
	endtask
	task automatic t_gap();
		mode(1'b0, 1'b0, 1'b0, 4);
		u_sensor.pixel(8'h11);
		u_sensor.pixel(8'h22);
		repeat (12) @(posedge ref_clk);
		chk("gap_flag", 10'(gap_error), 10'h001);
		chk("gap_count", 10'(q.size()), 10'h001);
		chk("gap_word", 10'(q[0][7:0]), 10'h022);
	endtask
	// Stalled consumer: FIFO fills, later pixels are dropped
	task automatic t_overflow();
		mode(1'b0, 1'b0, 1'b1, 20);
		px_ready <= 1'b0;
		for (int i = 0; i < 11; i++) u_sensor.pixel(8'(8'hd0 + i));
		repeat (12) @(posedge ref_clk);
		chk("ovf_flag", 10'(overflow), 10'h001);
		px_ready <= 1'b1;
		repeat (20) @(posedge ref_clk);
		chk("ovf_count", 10'(q.size()), 10'(`CSC_FIFO_DEPTH + 1));
		chk("ovf_word0", q[0], 10'h3d0);
	endtask
	// Reset for 6 cycles, then the scenarios in turn
	initial begin
		reset       <= 1'b1;
		gated_mode  <= 1'b1;
		vsync_fall  <= 1'b0;
		sample_fall <= 1'b0;
		px_ready    <= 1'b1;
		repeat (6) @(posedge ref_clk);
		reset <= 1'b0;
		t_gated();
		t_nongated();
		t_gap();
		t_overflow();
		summarize();
	end
endmodule
